// *** afs_pkg.sv ***
package afs_pkg;

    // Main clock derived from the system clock by a tick divider
    localparam longint CLK_HZ       = 10_000_000;
    localparam longint MCLK_HZ      = 76_800;
    localparam int     MCLK_DIV     = int'(CLK_HZ / MCLK_HZ);
    localparam int     DIV_W        = 8;
    localparam longint SETTLE_NS    = 416_600;
    localparam longint SETTLE_CALC  = (SETTLE_NS * MCLK_HZ + 64'd999_999_999) / 64'd1_000_000_000;
    localparam int     CNT_W        = 22;
    localparam logic [CNT_W-1:0] SETTLE_TICKS = CNT_W'(SETTLE_CALC);

    localparam int NUM_CH  = 4;
    localparam int FS_W    = 11;
    localparam int AVG_FACTOR = 8;

    // Register map (word index on the plain port)
    localparam logic [2:0] REG_CTRL   = 3'h0;
    localparam logic [2:0] REG_CHEN   = 3'h1;
    localparam logic [2:0] REG_SETUP0 = 3'h2;
    localparam logic [2:0] REG_SETUP1 = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;
    localparam logic [2:0] REG_COUNT  = 3'h5;

    // Field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CHEN_EN_LSB  = 0;
    localparam int CHEN_MAP_LSB = 8;
    localparam int SETUP_FS_LSB = 0;
    localparam int SETUP_MODE_LSB = 11;

    // Reset values
    localparam logic [15:0] SETUP_RST = 16'h0000;
    localparam logic [15:0] CHEN_RST  = 16'h0001;

    // Filter modes
    localparam logic [3:0] FM_SINC4    = 4'h0;
    localparam logic [3:0] FM_SINC4AVG = 4'h1;
    localparam logic [3:0] FM_SINC3    = 4'h2;
    localparam logic [3:0] FM_SINC3R60 = 4'h3;
    localparam logic [3:0] FM_SINC3AVG = 4'h4;
    localparam logic [3:0] FM_POST1    = 4'h5;
    localparam logic [3:0] FM_POST2    = 4'h6;
    localparam logic [3:0] FM_POST3    = 4'h7;
    localparam logic [3:0] FM_POST4    = 4'h8;

    // Cycle figures in main clocks
    localparam logic [CNT_W-1:0] BASE_MUL   = 22'h00_0020;
    localparam logic [CNT_W-1:0] POST1_CYC  = 22'h00_0b80;
    localparam logic [CNT_W-1:0] POST2_CYC  = 22'h00_0c80;
    localparam logic [CNT_W-1:0] POST3_CYC  = 22'h00_0f80;
    localparam logic [CNT_W-1:0] POST4_CYC  = 22'h00_1280;
    localparam logic [CNT_W-1:0] DPP_SHORT  = 22'h00_001c;
    localparam logic [CNT_W-1:0] DPP_LONG   = 22'h00_003e;
    localparam logic [CNT_W-1:0] DPP_POST   = 22'h00_0045;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SETTLE = 2'b01,
        ST_CONV   = 2'b11
    } afs_state_e;

    // Settled conversion period
    function automatic logic [CNT_W-1:0] settled_conversion_period_f(input logic [3:0] mode, input logic [FS_W-1:0] fs);
        logic [CNT_W-1:0] f;
        f = (fs == '0) ? CNT_W'(1) : CNT_W'(fs);
        case (mode)
            FM_SINC4AVG: settled_conversion_period_f = CNT_W'((4 + AVG_FACTOR - 1) * 32) * f;
            FM_SINC3AVG: settled_conversion_period_f = CNT_W'((3 + AVG_FACTOR - 1) * 32) * f;
            FM_POST1:    settled_conversion_period_f = POST1_CYC;
            FM_POST2:    settled_conversion_period_f = POST2_CYC;
            FM_POST3:    settled_conversion_period_f = POST3_CYC;
            FM_POST4:    settled_conversion_period_f = POST4_CYC;
            default:     settled_conversion_period_f = BASE_MUL * f;
        endcase
    endfunction : settled_conversion_period_f

    // Ideal first conversion on a fresh channel
    function automatic logic [CNT_W-1:0] ideal_f(input logic [3:0] mode, input logic [FS_W-1:0] fs);
        logic [CNT_W-1:0] t;
        t = settled_conversion_period_f(mode, fs);
        case (mode)
            FM_SINC4:             ideal_f = t << 2;
            FM_SINC3, FM_SINC3R60: ideal_f = CNT_W'(t * 22'h00_0003);
            default:              ideal_f = t;
        endcase
    endfunction : ideal_f

    // Post-processing length
    function automatic logic [CNT_W-1:0] dpp_f(input logic [3:0] mode, input logic [FS_W-1:0] fs);
        case (mode)
            FM_SINC4AVG, FM_SINC3AVG: dpp_f = DPP_LONG;
            FM_POST1, FM_POST2, FM_POST3, FM_POST4: dpp_f = DPP_POST;
            default: dpp_f = (fs <= FS_W'(1)) ? DPP_SHORT : DPP_LONG;
        endcase
    endfunction : dpp_f

endpackage : afs_pkg

// *** afs_seq_timing.sv ***
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
module afs_seq_timing
    import afs_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic [2:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [15:0]      rdata_o,
    output logic             data_ready_n_o,
    output logic [1:0]       input_crosspoint_mux_o,
    output logic             mod_filter_reset_o,
    output logic [1:0]       result_chan_o,
    output logic             seq_active_o
);

    logic [DIV_W-1:0]  div_q;
    logic              tick_q;
    logic              run_q;
    logic [3:0]        en_q;
    logic [3:0]        map_q;
    logic [15:0]       setup_q [2];
    afs_state_e        state_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  len_q;
    logic [1:0]        chan_q;
    logic [3:0]        mode_q;
    logic [FS_W-1:0]   fs_q;
    logic              dpp_busy_q;
    logic [CNT_W-1:0]  dpp_cnt_q;
    logic [CNT_W-1:0]  dpp_len_q;
    logic [1:0]        dpp_chan_q;
    logic              first_q;
    logic              dpp_sub_q;
    logic [15:0]       count_q;
    logic              drdy_n_q;
    logic              mrst_q;
    logic [15:0]       rdata_q;
    logic              multi;
    logic              conv_done;
    logic              settle_done;
    logic              dpp_done;
    logic [1:0]        nxt_chan;
    logic [15:0]       nxt_setup;

    // Next enabled channel above the given one, wrapping to the lowest
    function automatic logic [1:0] next_chan_f(input logic [1:0] cur, input logic [3:0] en);
        logic [1:0] c;
        next_chan_f = cur;
        for (int i = 1; i <= NUM_CH; i++) begin
            c = 2'(cur + 2'(i));
            if (en[c] && next_chan_f == cur) begin
                next_chan_f = c;
            end
        end
        if (!en[next_chan_f]) begin
            next_chan_f = cur;
        end
    endfunction : next_chan_f

    // Main clock tick; the divider is truncated so the rate runs slightly fast
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (div_q == DIV_W'(MCLK_DIV - 1)) begin
            div_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + DIV_W'(1);
            tick_q <= 1'b0;
        end
    end

    // Event decode
    assign multi       = ($countones(en_q) > 1);
    assign conv_done   = tick_q && state_q == ST_CONV && cnt_q == len_q - CNT_W'(1);
    assign settle_done = tick_q && state_q == ST_SETTLE && cnt_q == SETTLE_TICKS - CNT_W'(1);
    assign dpp_done    = tick_q && dpp_busy_q && dpp_cnt_q == dpp_len_q - CNT_W'(1);
    assign nxt_chan    = (state_q == ST_IDLE) ? next_chan_f(2'(NUM_CH - 1), en_q) : next_chan_f(chan_q, en_q);
    assign nxt_setup   = setup_q[map_q[nxt_chan]];

    // Register writes
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            run_q      <= 1'b0;
            en_q       <= CHEN_RST[3:0];
            map_q      <= '0;
            setup_q[0] <= SETUP_RST;
            setup_q[1] <= SETUP_RST;
        end else if (wr_i) begin
            case (addr_i)
                REG_CTRL:   run_q <= wdata_i[CTRL_RUN_BIT];
                REG_CHEN: begin
                    en_q  <= wdata_i[CHEN_EN_LSB +: 4];
                    map_q <= wdata_i[CHEN_MAP_LSB +: 4];
                end
                REG_SETUP0: setup_q[0] <= {1'b0, wdata_i[14:0]};
                REG_SETUP1: setup_q[1] <= {1'b0, wdata_i[14:0]};
                default: ;
            endcase
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else if (rd_i) begin
            case (addr_i)
                REG_CTRL:   rdata_q <= {15'h0000, run_q};
                REG_CHEN:   rdata_q <= {4'h0, map_q, 4'h0, en_q};
                REG_SETUP0: rdata_q <= setup_q[0];
                REG_SETUP1: rdata_q <= setup_q[1];
                REG_STATUS: rdata_q <= {8'h00, multi, dpp_busy_q, drdy_n_q, first_q, state_q, chan_q};
                REG_COUNT:  rdata_q <= count_q;
                default:    rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    // Conversion sequencer; config is latched per channel so later setup writes
    // never disturb a running conversion
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            len_q   <= '0;
            chan_q  <= '0;
            mode_q  <= FM_SINC4;
            fs_q    <= '0;
            first_q <= 1'b1;
            mrst_q  <= 1'b0;
        end else begin
            mrst_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (run_q && en_q != 4'h0) begin
                        state_q <= ST_SETTLE;
                        chan_q  <= nxt_chan;
                        mode_q  <= nxt_setup[SETUP_MODE_LSB +: 4];
                        fs_q    <= nxt_setup[SETUP_FS_LSB +: FS_W];
                        cnt_q   <= '0;
                        first_q <= 1'b1;
                        mrst_q  <= 1'b1;
                    end
                end
                ST_SETTLE: begin
                    if (!run_q) begin
                        state_q <= ST_IDLE;
                    end else if (settle_done) begin
                        state_q <= ST_CONV;
                        cnt_q   <= '0;
                        len_q   <= ideal_f(mode_q, fs_q);
                    end else if (tick_q) begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
                ST_CONV: begin
                    if (!run_q || en_q == 4'h0) begin
                        state_q <= ST_IDLE;
                    end else if (conv_done) begin
                        cnt_q <= '0;
                        if (multi || !en_q[chan_q]) begin
                            state_q <= ST_SETTLE;
                            chan_q  <= nxt_chan;
                            mode_q  <= nxt_setup[SETUP_MODE_LSB +: 4];
                            fs_q    <= nxt_setup[SETUP_FS_LSB +: FS_W];
                            first_q <= 1'b1;
                            mrst_q  <= 1'b1;
                        end else begin
                            len_q   <= settled_conversion_period_f(mode_q, fs_q);
                            first_q <= 1'b0;
                        end
                    end else if (tick_q) begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Post-processing runs beside the next channel's settling, or, with a single channel enabled, beside its next conversion
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            dpp_busy_q <= 1'b0;
            dpp_cnt_q  <= '0;
            dpp_len_q  <= '0;
            dpp_chan_q <= '0;
            dpp_sub_q  <= 1'b0;
        end else if (conv_done) begin
            dpp_busy_q <= 1'b1;
            dpp_cnt_q  <= '0;
            dpp_len_q  <= dpp_f(mode_q, fs_q);
            dpp_chan_q <= chan_q;
            dpp_sub_q  <= !first_q;
        end else if (dpp_done) begin
            dpp_busy_q <= 1'b0;
        end else if (tick_q && dpp_busy_q) begin
            dpp_cnt_q <= dpp_cnt_q + CNT_W'(1);
        end
    end

    // Ready rises when a conversion ends, falls once its result is processed
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            drdy_n_q      <= 1'b1;
            result_chan_o <= '0;
            count_q       <= '0;
        end else if (conv_done) begin
            drdy_n_q <= 1'b1;
        end else if (dpp_done) begin
            drdy_n_q      <= 1'b0;
            result_chan_o <= dpp_chan_q;
            count_q       <= count_q + 16'h0001;
        end
    end

    // Sequencing flag
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            seq_active_o <= 1'b0;
        end else begin
            seq_active_o <= multi && state_q != ST_IDLE;
        end
    end

    assign rdata_o                = rdata_q;
    assign data_ready_n_o         = drdy_n_q;
    assign input_crosspoint_mux_o = chan_q;
    assign mod_filter_reset_o     = mrst_q;

    // Checks
    logic [CNT_W-1:0] gap_q;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            gap_q <= '0;
        end else if (dpp_done) begin
            gap_q <= '0;
        end else if (tick_q) begin
            gap_q <= gap_q + CNT_W'(1);
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_conv_end;
        conv_done;
    endsequence
    sequence s_ready_up;
        ##1 drdy_n_q;
    endsequence

    chk_settle_length: assert property ((state_q == ST_CONV && $past(state_q) == ST_SETTLE) |-> $past(cnt_q) == SETTLE_TICKS - CNT_W'(1)) else $error("settle length wrong");
    chk_switch_reset: assert property (($changed(chan_q) && state_q != ST_IDLE) |-> mrst_q && state_q == ST_SETTLE) else $error("no reset on channel change");
    chk_seq_switch: assert property ((s_conv_end and (run_q && multi)) |=> state_q == ST_SETTLE) else $error("sequencer did not switch");
    chk_ready_rise: assert property ((s_conv_end and drdy_n_q == 1'b0) |-> s_ready_up) else $error("ready did not rise");
    chk_dpp_length: assert property (dpp_done |-> dpp_cnt_q == dpp_len_q - CNT_W'(1) && dpp_len_q >= DPP_SHORT) else $error("post-processing length wrong");
    chk_first_length: assert property ((conv_done && first_q) |-> cnt_q == ideal_f(mode_q, fs_q) - CNT_W'(1)) else $error("first conversion length wrong");
    chk_settled_gap: assert property ((dpp_done && dpp_sub_q) |-> gap_q == settled_conversion_period_f(mode_q, fs_q) - CNT_W'(1)) else $error("settled period wrong");
    chk_ascending_order: assert property ((conv_done && multi && run_q) |=> chan_q == next_chan_f($past(chan_q), en_q)) else $error("channel order wrong");
    chk_ready_falls: assert property (dpp_done |=> !drdy_n_q ##1 (drdy_n_q == 1'b0 || $past(conv_done))) else $error("ready fall lost");

endmodule : afs_seq_timing

// *** afs_host_model.sv ***
`timescale 1ns/1ns
// Host side of the ready line: it time-stamps each result as the host would see it
module afs_host_model (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       ready_n_i,
    input  wire logic [1:0] chan_i,
    input  wire logic [1:0] mux_i,
    input  wire logic       filt_rst_i,
    output int              cyc_o,
    output int              fall_cnt_o,
    output int              fall_cyc_o,
    output logic [1:0]      fall_chan_o,
    output logic [1:0]      fall_mux_o,
    output int              pulse_cnt_o
);
    logic rdy_q;

    // Free-running stamp in system clocks, so gaps are exact multiples of a tick
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cyc_o <= 0;
            rdy_q <= 1'b1;
        end else begin
            cyc_o <= cyc_o + 1;
            rdy_q <= ready_n_i;
        end
    end

    // Capture on the falling edge only; a held low level is one result, not many
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            fall_cnt_o  <= 0;
            fall_cyc_o  <= 0;
            fall_chan_o <= 2'h0;
            fall_mux_o  <= 2'h0;
        end else if (rdy_q && !ready_n_i) begin
            fall_cnt_o  <= fall_cnt_o + 1;
            fall_cyc_o  <= cyc_o;
            fall_chan_o <= chan_i;
            fall_mux_o  <= mux_i;
        end
    end

    // Channel selections seen, one per reset pulse
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pulse_cnt_o <= 0;
        end else if (filt_rst_i) begin
            pulse_cnt_o <= pulse_cnt_o + 1;
        end
    end
endmodule : afs_host_model

// *** tb_afs_seq_timing.sv ***
`timescale 1ns/1ns
module tb_afs_seq_timing
    import afs_pkg::*;
;
    localparam int TK = MCLK_DIV;
    logic        mclk_i  = 1'b0;
    logic        rst_i   = 1'b1;
    logic [2:0]  addr_i  = 3'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i    = 1'b0;
    logic        rd_i    = 1'b0;
    logic [15:0] rdata_o;
    logic        data_ready_n_o;
    logic [1:0]  input_crosspoint_mux_o;
    logic        mod_filter_reset_o;
    logic [1:0]  result_chan_o;
    logic        seq_active_o;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cyc, fall_cnt, fall_cyc, pulse_cnt;
    logic [1:0]  fall_chan, fall_mux;
    logic [15:0] v;
    int          t0, t1, t2, t3, n0, p0;

    afs_seq_timing DUT (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .data_ready_n_o(data_ready_n_o),
        .input_crosspoint_mux_o(input_crosspoint_mux_o), .mod_filter_reset_o(mod_filter_reset_o),
        .result_chan_o(result_chan_o), .seq_active_o(seq_active_o));

    afs_host_model host (.mclk_i(mclk_i), .rst_i(rst_i), .ready_n_i(data_ready_n_o),
        .chan_i(result_chan_o), .mux_i(input_crosspoint_mux_o), .filt_rst_i(mod_filter_reset_o),
        .cyc_o(cyc), .fall_cnt_o(fall_cnt), .fall_cyc_o(fall_cyc), .fall_chan_o(fall_chan),
        .fall_mux_o(fall_mux), .pulse_cnt_o(pulse_cnt));

    // 10 MHz system clock
    always #50 mclk_i = ~mclk_i;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask : wr

    // Read data is looked at only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #10 d = rdata_o;
    endtask : rd

    // Bounded wait for the host model to see result number n
    task automatic wait_fall(input int n, output int t);
        int k;
        for (k = 0; k < 60000 && fall_cnt < n; k++) @(posedge mclk_i);
        #10 t = fall_cyc;
        chk("fall_seen", 32'(fall_cnt >= n), 32'h0000_0001);
    endtask : wait_fall

    // True when a first result lands within one tick of phase slack; the first
    // tick after the start may come anywhere from 1 to TK cycles later
    function automatic logic [31:0] in_win(input int seen, input int ticks);
        return 32'(seen >= (ticks - 1) * TK && seen <= ticks * TK + 8);
    endfunction : in_win

    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    // Watchdog sized past both tests, about 95k cycles
    initial begin
        #9_500_000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        // Register port basics
        rd(REG_CHEN, v);
        chk("chen_reset", 32'(v), 32'(CHEN_RST));
        @(posedge mclk_i);
        #10 chk("rdata_one_cycle", 32'(rdata_o), 32'h0000_0000);
        rd(3'h6, v);
        chk("unmapped_read", 32'(v), 32'h0000_0000);
        wr(REG_SETUP1, 16'ha002);
        rd(REG_SETUP1, v);
        chk("setup1_readback", 32'(v), 32'h0000_2002);
        // Single channel, sinc4, decimation 1
        wr(REG_SETUP0, 16'h0001);
        wr(REG_CTRL, 16'h0001);
        // Run is latched at the write edge; the selection pulse follows one edge later
        @(posedge mclk_i);
        #10 t0 = cyc;
        chk("mod_reset_pulse", 32'(mod_filter_reset_o), 32'h0000_0001);
        chk("mux_first", 32'(input_crosspoint_mux_o), 32'h0000_0000);
        rd(REG_STATUS, v);
        chk("state_settle", 32'(v[3:2]), 32'h0000_0001);
        chk("seq_single", 32'(seq_active_o), 32'h0000_0000);
        wait_fall(1, t1);
        chk("first_sinc4", in_win(t1 - t0, 32 + 4 * 32 + 28), 32'h0000_0001);
        wait_fall(2, t2);
        chk("settled_gap", 32'(t2 - t1), 32'(32 * TK));
        chk("single_chan", 32'(fall_chan), 32'h0000_0000);
        rd(REG_COUNT, v);
        chk("result_count", 32'(v), 32'h0000_0002);
        wr(REG_CTRL, 16'h0000);
        $display("Test single channel finished");
        // Two channels on one sinc3 setup, three results: channel 0, channel 1, then channel 0 again
        wr(REG_CHEN, 16'h0003);
        wr(REG_SETUP0, 16'h1001);
        n0 = fall_cnt;
        p0 = pulse_cnt;
        wr(REG_CTRL, 16'h0001);
        @(posedge mclk_i);
        #10 t0 = cyc;
        rd(REG_STATUS, v);
        chk("seq_multi", 32'(seq_active_o), 32'h0000_0001);
        wait_fall(n0 + 1, t1);
        chk("first_sinc3", in_win(t1 - t0, 32 + 3 * 32 + 28), 32'h0000_0001);
        chk("seq_chan0", 32'(fall_chan), 32'h0000_0000);
        chk("early_switch", 32'(fall_mux), 32'h0000_0001);
        wait_fall(n0 + 2, t2);
        chk("seq_gap1", 32'(t2 - t1), 32'((32 + 3 * 32 + 28 - 28) * TK));
        chk("seq_chan1", 32'(fall_chan), 32'h0000_0001);
        chk("wrap_mux", 32'(fall_mux), 32'h0000_0000);
        wait_fall(n0 + 3, t3);
        chk("seq_gap2", 32'(t3 - t2), 32'((32 + 3 * 32) * TK));
        chk("seq_wrap", 32'(fall_chan), 32'h0000_0000);
        chk("reselects", 32'(pulse_cnt - p0), 32'h0000_0004);
        $display("Test sequencer finished");
        give_verdict();
    end
endmodule : tb_afs_seq_timing
